// ---- logic/upc_pkg.sv ----
/*
 * Package for the USB clock loop control block: register addresses,
 * field positions, reset values and the lock detector timing.
 * Assumes an 8-bit special-function register space with byte addresses.
 */
package upc_pkg;
    // special-function register addresses
    localparam logic [7:0] ADDR_PLL_CONTROL = 8'hA3;
    localparam logic [7:0] ADDR_PLL_DIVIDER = 8'hA4;
    // control register fields
    localparam int BIT_BYPASS = 2;
    localparam int BIT_ENABLE = 1;
    localparam int BIT_LOCKED = 0;
    // reset values
    localparam logic [7:0] RST_PLL_CONTROL = 8'h00;
    localparam logic [7:0] RST_PLL_DIVIDER = 8'h00;
    // divider field positions
    localparam int FB_HI = 7;
    localparam int FB_LO = 4;
    localparam int REF_HI = 3;
    localparam int REF_LO = 0;
    // matching phase comparisons needed before lock is declared
    localparam logic [3:0] LOCK_MATCHES = 4'h8;
endpackage

// ---- logic/upc_pll_ctrl.sv ----
/*
 * Control and divider registers of the loop that makes the USB clock,
 * with a digital model of the loop's dividers and lock detector.
 * Assumes a processor special-function register port with one-cycle
 * write and read strobes, and a loop oscillator model outside that
 * supplies its divided output as a level sampled on clk.
 */
`timescale 1ns/10ps
`default_nettype none

module upc_pll_ctrl
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic sfr_rdata_valid,
    input wire logic loop_clk_div_in,
    output logic external_clock_bypass,
    output logic crystal_osc_enable,
    output logic usb_clk_from_loop,
    output logic loop_enable,
    output logic loop_locked_flag,
    output logic [3:0] feedback_divider_field,
    output logic [3:0] reference_divider_field,
    output logic ref_tick,
    output logic fb_tick
);

    ////////////////////////////////////////////////////////////////////////
    // state record

    typedef struct packed {
        logic bypass;
        logic enable;
        logic locked;
        logic osc_en;
        logic usb_from_loop;
        logic [3:0] fb_field;
        logic [3:0] ref_field;
        logic [3:0] ref_cnt;
        logic [3:0] fb_cnt;
        logic ref_pend;
        logic fb_pend;
        logic [3:0] match_cnt;
        logic [2:0] sync;
        logic loop_prev;
        logic ref_tick;
        logic fb_tick;
        logic [7:0] rdata;
        logic rvalid;
    } upc_state_t;

    upc_state_t st;
    upc_state_t next_st;

    logic loop_edge;

    // a rising change counts once the second and third stages agree
    assign loop_edge = (st.sync[2] == st.sync[1]) && st.sync[1]
        && !st.loop_prev;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb
    begin
        next_st = st;
        next_st.ref_tick = 1'b0;
        next_st.fb_tick = 1'b0;
        next_st.rvalid = 1'b0;
        // three-stage synchroniser on the divided oscillator pin
        next_st.sync = {st.sync[1:0], loop_clk_div_in};
        if (st.sync[2] == st.sync[1])
        begin
            next_st.loop_prev = st.sync[1];
        end

        // register writes; lock bit is never taken from the bus
        if (sfr_wr)
        begin
            if (sfr_addr == upc_pkg::ADDR_PLL_CONTROL)
            begin
                next_st.bypass = sfr_wdata[upc_pkg::BIT_BYPASS];
                next_st.enable = sfr_wdata[upc_pkg::BIT_ENABLE];
            end
            else if (sfr_addr == upc_pkg::ADDR_PLL_DIVIDER)
            begin
                next_st.fb_field =
                    sfr_wdata[upc_pkg::FB_HI:upc_pkg::FB_LO];
                next_st.ref_field =
                    sfr_wdata[upc_pkg::REF_HI:upc_pkg::REF_LO];
            end
        end

        // clock steering follows the bypass bit
        next_st.osc_en = !next_st.bypass;
        next_st.usb_from_loop = !next_st.bypass;

        // reference divider on the peripheral clock, ratio ref_field+1
        if (!st.enable)
        begin
            next_st.ref_cnt = 4'h0;
            next_st.fb_cnt = 4'h0;
            next_st.ref_pend = 1'b0;
            next_st.fb_pend = 1'b0;
            next_st.match_cnt = 4'h0;
            next_st.locked = 1'b0;
        end
        else
        begin
            if (st.ref_cnt == st.ref_field)
            begin
                next_st.ref_cnt = 4'h0;
                next_st.ref_tick = 1'b1;
            end
            else
            begin
                next_st.ref_cnt = st.ref_cnt + 4'h1;
            end
            // feedback divider on the loop output, ratio fb_field+1
            if (loop_edge)
            begin
                if (st.fb_cnt == st.fb_field)
                begin
                    next_st.fb_cnt = 4'h0;
                    next_st.fb_tick = 1'b1;
                end
                else
                begin
                    next_st.fb_cnt = st.fb_cnt + 4'h1;
                end
            end
            // phase comparison: each reference tick must pair with one
            // feedback tick before the next reference tick arrives
            if (next_st.ref_tick && next_st.fb_tick)
            begin
                next_st.ref_pend = 1'b0;
                next_st.fb_pend = 1'b0;
                if (st.match_cnt != upc_pkg::LOCK_MATCHES)
                begin
                    next_st.match_cnt = st.match_cnt + 4'h1;
                end
            end
            else if (next_st.ref_tick)
            begin
                if (st.fb_pend)
                begin
                    next_st.fb_pend = 1'b0;
                    next_st.match_cnt = (st.match_cnt
                        == upc_pkg::LOCK_MATCHES) ? st.match_cnt
                        : st.match_cnt + 4'h1;
                end
                else if (st.ref_pend)
                begin
                    next_st.match_cnt = 4'h0; // feedback missed a cycle
                end
                else
                begin
                    next_st.ref_pend = 1'b1;
                end
            end
            else if (next_st.fb_tick)
            begin
                if (st.ref_pend)
                begin
                    next_st.ref_pend = 1'b0;
                    next_st.match_cnt = (st.match_cnt
                        == upc_pkg::LOCK_MATCHES) ? st.match_cnt
                        : st.match_cnt + 4'h1;
                end
                else if (st.fb_pend)
                begin
                    next_st.match_cnt = 4'h0; // feedback runs too fast
                end
                else
                begin
                    next_st.fb_pend = 1'b1;
                end
            end
            // flag tracks the detector, high only after enough matches
            next_st.locked =
                (next_st.match_cnt == upc_pkg::LOCK_MATCHES);
        end

        // register reads, reserved control bits return zero
        if (sfr_rd)
        begin
            next_st.rvalid = 1'b1;
            if (sfr_addr == upc_pkg::ADDR_PLL_CONTROL)
            begin
                next_st.rdata = 8'h00;
                next_st.rdata[upc_pkg::BIT_BYPASS] = st.bypass;
                next_st.rdata[upc_pkg::BIT_ENABLE] = st.enable;
                next_st.rdata[upc_pkg::BIT_LOCKED] = st.locked;
            end
            else if (sfr_addr == upc_pkg::ADDR_PLL_DIVIDER)
            begin
                next_st.rdata = {st.fb_field, st.ref_field};
            end
            else
            begin
                next_st.rdata = 8'h00; // not ours, answer zero
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            // reset image: both registers cleared, oscillator running
            st <= '0;
            st.bypass <= upc_pkg::RST_PLL_CONTROL[upc_pkg::BIT_BYPASS];
            st.enable <= upc_pkg::RST_PLL_CONTROL[upc_pkg::BIT_ENABLE];
            st.locked <= upc_pkg::RST_PLL_CONTROL[upc_pkg::BIT_LOCKED];
            st.fb_field <=
                upc_pkg::RST_PLL_DIVIDER[upc_pkg::FB_HI:upc_pkg::FB_LO];
            st.ref_field <=
                upc_pkg::RST_PLL_DIVIDER[upc_pkg::REF_HI:upc_pkg::REF_LO];
            // steering outputs follow the cleared bypass bit
            st.osc_en <= !upc_pkg::RST_PLL_CONTROL[upc_pkg::BIT_BYPASS];
            st.usb_from_loop <=
                !upc_pkg::RST_PLL_CONTROL[upc_pkg::BIT_BYPASS];
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state flip-flops

    assign external_clock_bypass = st.bypass;
    assign crystal_osc_enable = st.osc_en;
    assign usb_clk_from_loop = st.usb_from_loop;
    assign loop_enable = st.enable;
    assign loop_locked_flag = st.locked;
    assign feedback_divider_field = st.fb_field;
    assign reference_divider_field = st.ref_field;
    assign ref_tick = st.ref_tick;
    assign fb_tick = st.fb_tick;
    assign sfr_rdata = st.rdata;
    assign sfr_rdata_valid = st.rvalid;

endmodule

`default_nettype wire

// ---- testbench/upc_pll_ctrl_asserts.sv ----
/* checker for the loop control block.
   assumes it is bound onto the ports of upc_pll_ctrl */
`timescale 1ns/10ps
`default_nettype none
module upc_pll_ctrl_asserts
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rdata_valid,
    input wire logic external_clock_bypass,
    input wire logic crystal_osc_enable,
    input wire logic usb_clk_from_loop,
    input wire logic loop_enable,
    input wire logic loop_locked_flag,
    input wire logic [3:0] feedback_divider_field,
    input wire logic [3:0] reference_divider_field,
    input wire logic ref_tick,
    input wire logic fb_tick
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // decoded write strobes and control read strobe
    wire logic wr_ctl = sfr_wr && sfr_addr == upc_pkg::ADDR_PLL_CONTROL;
    wire logic wr_div = sfr_wr && sfr_addr == upc_pkg::ADDR_PLL_DIVIDER;
    wire logic rd_ctl = sfr_rd && sfr_addr == upc_pkg::ADDR_PLL_CONTROL;
    ////////////////////////////////////////
    a_osc_gate: assert property (
        crystal_osc_enable == !external_clock_bypass)
        else $error("oscillator enable disagrees with bypass");
    a_usb_src: assert property (
        usb_clk_from_loop == !external_clock_bypass)
        else $error("usb clock source disagrees with bypass");
    a_bypass_wr: assert property (wr_ctl |=>
        external_clock_bypass == $past(sfr_wdata[2]))
        else $error("bypass bit not written");
    a_enable_wr: assert property (wr_ctl |=>
        loop_enable == $past(sfr_wdata[1]))
        else $error("enable bit not written");
    a_div_wr: assert property (wr_div |=>
        {feedback_divider_field, reference_divider_field} == $past(sfr_wdata))
        else $error("divider fields not written");
    a_ctl_read: assert property (rd_ctl |=> sfr_rdata_valid &&
        sfr_rdata == {5'h00, $past(external_clock_bypass),
        $past(loop_enable), $past(loop_locked_flag)})
        else $error("control read data wrong");
    a_lock_drop: assert property (
        !loop_enable |=> !loop_locked_flag)
        else $error("lock flag set while loop stopped");
    a_tick_idle: assert property (
        !loop_enable |=> !ref_tick && !fb_tick)
        else $error("divider ticks while loop stopped");
    a_lock_tick: assert property (
        $rose(loop_locked_flag) |-> ref_tick || fb_tick)
        else $error("lock flag rose without a phase comparison");
    a_reset_clr: assert property ($fell(sys_rst) |->
        !external_clock_bypass && !loop_enable && !loop_locked_flag &&
        feedback_divider_field == 4'h0 && reference_divider_field == 4'h0)
        else $error("registers not cleared by reset");
    // main scenarios reached
    c_lock: cover property ($rose(loop_locked_flag));
    c_bypass: cover property ($rose(external_clock_bypass));
    c_read: cover property (rd_ctl ##1 sfr_rdata_valid);
endmodule
`default_nettype wire

// ---- testbench/usb_pll_clock_control_test.sv ----
/* self-checking bench for the loop control block.
   assumes upc_pkg, upc_pll_ctrl and the checker are compiled first */
`timescale 1ns/10ps
`default_nettype none
module usb_pll_clock_control_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic loop_clk_div_in = 1'b0;
    logic osc_run = 1'b0;
    logic [1:0] osc_cnt = 2'h0;
    logic [7:0] d;
    logic [7:0] exp_q[$];
    int errors = 0;
    int compares = 0;
    wire logic [7:0] sfr_rdata;
    wire logic sfr_rdata_valid, external_clock_bypass, crystal_osc_enable;
    wire logic usb_clk_from_loop, loop_enable, loop_locked_flag;
    wire logic [3:0] feedback_divider_field, reference_divider_field;
    wire logic ref_tick, fb_tick;
    logic [7:0] ref_cnt = 8'h00, fb_cnt = 8'h00;
    logic [7:0] ref_gap = 8'h00, fb_gap = 8'h00;
    localparam logic [7:0] CTL = upc_pkg::ADDR_PLL_CONTROL;
    localparam logic [7:0] DIV = upc_pkg::ADDR_PLL_DIVIDER;
    upc_pll_ctrl dut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .sfr_rdata_valid(sfr_rdata_valid),
        .loop_clk_div_in(loop_clk_div_in),
        .external_clock_bypass(external_clock_bypass),
        .crystal_osc_enable(crystal_osc_enable),
        .usb_clk_from_loop(usb_clk_from_loop), .loop_enable(loop_enable),
        .loop_locked_flag(loop_locked_flag),
        .feedback_divider_field(feedback_divider_field),
        .reference_divider_field(reference_divider_field),
        .ref_tick(ref_tick), .fb_tick(fb_tick));
    always #25 clk = ~clk;
    // test oscillator: period of four clocks, stopped when not wanted
    always @(posedge clk)
    begin
        osc_cnt <= osc_cnt + 2'h1;
        loop_clk_div_in <= osc_run & osc_cnt[1];
    end
    // clocks between tick pulses, for the divide-ratio checks
    always @(posedge clk)
    begin
        ref_cnt <= (ref_tick === 1'b1) ? 8'h01 : ref_cnt + 8'h01;
        fb_cnt <= (fb_tick === 1'b1) ? 8'h01 : fb_cnt + 8'h01;
        if (ref_tick === 1'b1)
            ref_gap <= ref_cnt;
        if (fb_tick === 1'b1)
            fb_gap <= fb_cnt;
    end
    task chk(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want)
        begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // strobes drop at the edge that takes them, so calls never overlap
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
    endtask
    task finish_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // read data monitor: oldest note against each valid pulse
    always @(posedge clk)
    begin
        if (sfr_rdata_valid === 1'b1)
            chk(sfr_rdata, exp_q.pop_front());
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        finish_test();
    end
    ////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h311b));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd(CTL, 8'h00);
        rd(DIV, 8'h00);
        chk({7'h00, crystal_osc_enable}, 8'h01);
        $display("test reset done");
        wr(CTL, 8'h07);
        rd(CTL, 8'h06);
        chk({7'h00, crystal_osc_enable}, 8'h00);
        wr(CTL, 8'h00);
        rd(CTL, 8'h00);
        chk({7'h00, usb_clk_from_loop}, 8'h01);
        $display("test control bits done");
        for (int i = 0; i < 8; i++)
        begin
            d = 8'($urandom);
            wr(DIV, d);
            rd(DIV, d);
        end
        wr(8'hA5, 8'hFF);
        rd(8'hA5, 8'h00);
        rd(DIV, d);
        $display("test divider done");
        wr(DIV, 8'h17);
        osc_run <= 1'b1;
        wr(CTL, 8'h02);
        for (int i = 0; i < 300 && loop_locked_flag !== 1'b1; i++)
            @(posedge clk);
        chk({7'h00, loop_locked_flag}, 8'h01);
        chk(ref_gap, 8'h08);
        chk(fb_gap, 8'h08);
        wr(CTL, 8'h02);
        rd(CTL, 8'h03);
        // feedback stops: unpaired reference ticks must drop the lock
        osc_run <= 1'b0;
        repeat (40) @(posedge clk);
        rd(CTL, 8'h02);
        wr(CTL, 8'h00);
        repeat (2) @(posedge clk);
        rd(CTL, 8'h00);
        repeat (3) @(posedge clk);
        $display("test lock done");
        finish_test();
    end
endmodule
bind upc_pll_ctrl upc_pll_ctrl_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .sfr_rdata_valid(sfr_rdata_valid),
    .external_clock_bypass(external_clock_bypass),
    .crystal_osc_enable(crystal_osc_enable),
    .usb_clk_from_loop(usb_clk_from_loop), .loop_enable(loop_enable),
    .loop_locked_flag(loop_locked_flag),
    .feedback_divider_field(feedback_divider_field),
    .reference_divider_field(reference_divider_field),
    .ref_tick(ref_tick), .fb_tick(fb_tick));
`default_nettype wire
